// ===== design/acc_pkg.sv
// types for the conversion control block
`default_nettype none
package acc_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_CONV, ST_NAP, ST_SLEEP, ST_WAKE} acc_state_t;
    typedef struct packed {
        logic power_down_n;
        logic chip_sel_n;
        logic read_n;
        logic conversion_start_n;
    } acc_ctrl_t;
endpackage
`default_nettype wire

// ===== design/acc_regs.svh
// timing and field constants for the conversion control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_CLK_PERIOD_PS 8000
`define ACC_NAP_WAKE_NS 200
`define ACC_NAP_WAKE_CYC ((`ACC_NAP_WAKE_NS * 1000) / `ACC_CLK_PERIOD_PS)
`define ACC_CONV_MAX_NS 2200
`define ACC_CONV_CYC ((`ACC_CONV_MAX_NS * 1000) / `ACC_CLK_PERIOD_PS)
`define ACC_SLEEP_WAKE_MS 20
`define ACC_SLEEP_WAKE_CYC ((`ACC_SLEEP_WAKE_MS * 1000000) / (`ACC_CLK_PERIOD_PS / 1000))
`define ACC_DATA_W 14
`define ACC_FIFO_DEPTH 8
`endif

// ===== design/acc_top.sv
// conversion control, shutdown and result output of the sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic ready_r;
    // ready is registered so the write side sees a clean flop
    wire full = !ready_r;
    wire empty = (wp_r == rp_r);
    wire do_wr = wr_valid_in && !full;
    wire do_rd = rd_ready_in && !empty;
    wire [AW:0] wp_nxt = wp_r + (AW+1)'(do_wr);
    wire [AW:0] rp_nxt = rp_r + (AW+1)'(do_rd);
    wire full_nxt = (wp_nxt[AW] != rp_nxt[AW]) && (wp_nxt[AW-1:0] == rp_nxt[AW-1:0]);
    assign wr_ready_out = ready_r;
    assign rd_valid_out = !empty;
    assign rd_data_out = mem_r[rp_r[AW-1:0]];
    always_ff @(posedge clk_in)
    begin
        if (do_wr)
            mem_r[wp_r[AW-1:0]] <= wr_data_in;
    end
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wp_r <= '0;
            rp_r <= '0;
            ready_r <= 1'b1;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            ready_r <= !full_nxt;
        end
    end
endmodule

module acc_top (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic power_down_n_in,
    input wire logic chip_sel_n_in,
    input wire logic read_n_in,
    input wire logic conversion_start_n_in,
    input wire logic [`ACC_DATA_W-1:0] sample_in,
    input wire logic sample_valid_in,
    output logic sample_ready_out,
    output logic busy_n_out,
    output logic [`ACC_DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    output logic nap_out,
    output logic sleep_out
);
    localparam int CONV_CYC = `ACC_CONV_CYC;
    localparam int NAP_CYC = `ACC_NAP_WAKE_CYC;
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    acc_pkg::acc_ctrl_t ctl;
    assign ctl = acc_pkg::acc_ctrl_t'(s2_r);
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_r <= 4'hF;
            s2_r <= 4'hF;
        end
        else
        begin
            s1_r <= {power_down_n_in, chip_sel_n_in, read_n_in, conversion_start_n_in};
            s2_r <= s1_r;
        end
    end

    acc_pkg::acc_state_t state_r;
    acc_pkg::acc_state_t state_nxt;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic start_d_r;
    logic [`ACC_DATA_W-1:0] result_r;
    logic busy_n_nxt;
    logic [`ACC_DATA_W-1:0] fifo_data;
    logic fifo_valid;

    wire start_req = !ctl.conversion_start_n && !ctl.chip_sel_n && ctl.power_down_n;
    wire start_fall = start_req && start_d_r;
    wire conv_done = (state_r == acc_pkg::ST_CONV) && (cnt_r == 9'(CONV_CYC - 1)) && fifo_valid;
    wire wake_done = (state_r == acc_pkg::ST_WAKE) && (cnt_r == 9'(NAP_CYC - 1));
    wire take_sample = conv_done;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            acc_pkg::ST_IDLE:
            begin
                cnt_nxt = '0;
                if (!ctl.power_down_n)
                    state_nxt = ctl.chip_sel_n ? acc_pkg::ST_SLEEP : acc_pkg::ST_NAP;
                else if (start_fall)
                    state_nxt = acc_pkg::ST_CONV;
            end
            acc_pkg::ST_CONV:
            begin
                if (cnt_r != 9'(CONV_CYC - 1))
                    cnt_nxt = cnt_r + 9'h001;
                if (conv_done)
                    state_nxt = acc_pkg::ST_IDLE;
            end
            acc_pkg::ST_NAP, acc_pkg::ST_SLEEP:
            begin
                cnt_nxt = '0;
                if (ctl.power_down_n)
                    state_nxt = acc_pkg::ST_WAKE;
            end
            acc_pkg::ST_WAKE:
            begin
                cnt_nxt = cnt_r + 9'h001;
                if (!ctl.power_down_n)
                    state_nxt = ctl.chip_sel_n ? acc_pkg::ST_SLEEP : acc_pkg::ST_NAP;
                else if (wake_done)
                    state_nxt = acc_pkg::ST_IDLE;
            end
        endcase
    end

    assign busy_n_nxt = !(state_nxt == acc_pkg::ST_CONV);
    wire oe_n_nxt = !(!ctl.chip_sel_n && !ctl.read_n);

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r <= acc_pkg::ST_IDLE;
            cnt_r <= '0;
            start_d_r <= 1'b0;
            result_r <= '0;
            busy_n_out <= 1'b1;
            data_oe_n_out <= 1'b1;
            nap_out <= 1'b0;
            sleep_out <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            start_d_r <= !start_req;
            if (take_sample)
                result_r <= fifo_data;
            busy_n_out <= busy_n_nxt;
            data_oe_n_out <= oe_n_nxt;
            nap_out <= (state_nxt == acc_pkg::ST_NAP);
            sleep_out <= (state_nxt == acc_pkg::ST_SLEEP);
        end
    end
    assign data_out = result_r;

    acc_fifo #(.WIDTH(`ACC_DATA_W), .DEPTH(`ACC_FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_data_in(sample_in),
        .wr_valid_in(sample_valid_in),
        .wr_ready_out(sample_ready_out),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(take_sample)
    );

    sequence conv_run_s;
        !busy_n_out [*8];
    endsequence
    property busy_hold_p;
        @(posedge clk_in) disable iff (!arst_n_in)
        $fell(busy_n_out) |-> conv_run_s;
    endproperty
    busy_hold_a: assert property (busy_hold_p) else $error("busy released early");
    conv_ignore_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $past(state_r == acc_pkg::ST_CONV) && !$past(conv_done) |-> state_r == acc_pkg::ST_CONV)
        else $error("conversion restarted");
    conv_length_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(busy_n_out) |-> $past(state_r == acc_pkg::ST_CONV) && $past(cnt_r) == 9'(CONV_CYC - 1))
        else $error("conversion length wrong");
    start_select_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_r == acc_pkg::ST_IDLE && ctl.chip_sel_n |=> state_r != acc_pkg::ST_CONV)
        else $error("start while deselected");
    shut_enter_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_r == acc_pkg::ST_IDLE && !ctl.power_down_n |=> ##1 (nap_out || sleep_out))
        else $error("shutdown missed");
    nap_type_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_r == acc_pkg::ST_IDLE && !ctl.power_down_n && !ctl.chip_sel_n |=> ##1 nap_out)
        else $error("wrong shutdown type");
    nap_wake_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $past(state_r == acc_pkg::ST_WAKE) && state_r == acc_pkg::ST_IDLE |-> $past(cnt_r) == 9'(NAP_CYC - 1))
        else $error("woke too early");
    oe_read_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ctl.read_n |=> data_oe_n_out)
        else $error("outputs driven without read");
endmodule

`default_nettype wire

// ===== verification/acc_host_model.sv
// host model: holds the combined read/start strobe low until busy rises
`timescale 1ns/1ps
`default_nettype none
module acc_host_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic busy_n_in,
    output logic strobe_n_out
);
    logic seen_r;
    initial strobe_n_out = 1'b1;
    initial seen_r = 1'b0;
    always @(posedge clk_in)
    begin
        if (go_in && strobe_n_out)
        begin
            strobe_n_out <= 1'b0;
            seen_r <= 1'b0;
        end
        else if (!strobe_n_out && !busy_n_in)
            seen_r <= 1'b1;
        else if (!strobe_n_out && seen_r)
            strobe_n_out <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== verification/tb_acc_top.sv
// testbench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module tb_acc_top;
    logic clk_in = 1'b0;
    logic arst_n = 1'b0;
    logic pd_n = 1'b1, cs_n = 1'b0, rd_n = 1'b1, cv_n = 1'b1, sv = 1'b0, slow = 1'b0, go = 1'b0;
    logic [13:0] smp = 14'h0000;
    logic [13:0] dout;
    logic rdy, busy_n, oe_n, nap, sleep, strobe_n;
    wire logic rd_w = slow ? strobe_n : rd_n;
    wire logic cv_w = slow ? strobe_n : cv_n;
    int mismatches = 0;
    int checked = 0;
    acc_top DUT (.clk_in(clk_in), .arst_n_in(arst_n), .power_down_n_in(pd_n), .chip_sel_n_in(cs_n),
        .read_n_in(rd_w), .conversion_start_n_in(cv_w), .sample_in(smp), .sample_valid_in(sv),
        .sample_ready_out(rdy), .busy_n_out(busy_n), .data_out(dout), .data_oe_n_out(oe_n),
        .nap_out(nap), .sleep_out(sleep));
    acc_host_model host (.clk_in(clk_in), .go_in(go), .busy_n_in(busy_n), .strobe_n_out(strobe_n));
    initial forever #4 clk_in = ~clk_in;
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task chk(input logic [13:0] got, input logic [13:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task pulse_start;
        cv_n <= 1'b0;
        cyc(3);
        cv_n <= 1'b1;
    endtask
    task wait_low;
        repeat (20) if (busy_n !== 1'b0) cyc(1);
        chk(busy_n, 1'b0);
    endtask
    task wait_high(input logic [13:0] exp);
        repeat (280) if (busy_n !== 1'b1) cyc(1);
        chk(busy_n, 1'b1);
        chk(dout, exp);
    endtask
    task fill_fifo;
        sv <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            smp <= 14'h2000 + 14'(i);
            cyc(1);
        end
        sv <= 1'b0;
        cyc(1);
        chk(rdy, 1'b0);
    endtask
    task mode_tied;
        rd_n <= 1'b0;
        pulse_start();
        cyc(100);
        pulse_start();
        cyc(172);
        chk(busy_n, 1'b0);
        cyc(1);
        chk(busy_n, 1'b1);
        wait_high(14'h2000);
        chk(oe_n, 1'b0);
        cyc(12);
        chk(busy_n, 1'b1);
    endtask
    task unselected_and_read;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        pulse_start();
        cyc(10);
        chk(busy_n, 1'b1);
        cs_n <= 1'b0;
        cyc(5);
        chk(oe_n, 1'b1);
        rd_n <= 1'b0;
        cyc(5);
        chk(oe_n, 1'b0);
    endtask
    task slow_memory;
        slow <= 1'b1;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        wait_low();
        chk(dout, 14'h2000);
        wait_high(14'h2001);
        cyc(3);
        chk(strobe_n, 1'b1);
        slow <= 1'b0;
    endtask
    task rom_mode;
        rd_n <= 1'b0;
        cv_n <= 1'b0;
        cyc(6);
        chk(dout, 14'h2001);
        rd_n <= 1'b1;
        cv_n <= 1'b1;
        wait_low();
        wait_high(14'h2002);
    endtask
    task shutdown;
        pd_n <= 1'b0;
        cyc(6);
        chk(nap, 1'b1);
        pd_n <= 1'b1;
        cyc(30);
        chk(nap, 1'b0);
        pulse_start();
        wait_low();
        wait_high(14'h2003);
        cs_n <= 1'b1;
        cyc(1);
        pd_n <= 1'b0;
        cyc(6);
        chk(sleep, 1'b1);
        pd_n <= 1'b1;
        cyc(30);
        chk(sleep, 1'b0);
        chk(busy_n, 1'b1);
    endtask
    initial
    begin
        cyc(12);
        arst_n <= 1'b1;
        cyc(2);
        fill_fifo();
        mode_tied();
        unselected_and_read();
        slow_memory();
        rom_mode();
        shutdown();
        end_sim();
    end
    initial
    begin
        #20us;
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
